//--- core/be_former.sv
// Purpose: requester-side former of header byte 7 with self check
// Assumes: user supplies start byte address and byte count of request
// Notes:   one request per cycle at most; outputs registered
//          raw headers are checked like formed ones, never formed
`timescale 1ns/100ps
module be_former (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              check_enable,
  input  wire logic              req_valid,
  input  wire be_pkg::req_kind_t req_kind,
  input  wire logic [63:0]       req_addr,
  input  wire logic [12:0]       req_bytes,
  input  wire logic              req_flush,
  input  wire logic              req_nonprefetch,
  input  wire logic              processing_hint_flag,
  input  wire logic [7:0]        steering_tag_field,
  input  wire logic [2:0]        service_class_field,
  input  wire logic              raw_valid,
  input  wire logic [7:0]        raw_byte7,
  input  wire logic [9:0]        raw_len,
  input  wire logic              raw_mem,
  output logic                   hdr_valid,
  output logic [7:0]             hdr_byte7,
  output logic [9:0]             hdr_len,
  output logic [61:0]            hdr_dw_addr,
  output logic [2:0]             hdr_class,
  output logic                   hdr_hint,
  output logic                   hdr_discard,
  output logic                   malformed_err,
  output logic [3:0]             impl_first_be,
  output logic [3:0]             impl_final_be
);
  import be_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // forming: enables from address and byte count
  logic [3:0]  first_d;
  logic [3:0]  final_d;
  logic [9:0]  len_d;
  logic [63:0] end_addr;
  logic [13:0] span;
  logic        hint_ok;

  assign end_addr = req_addr + {51'h0, req_bytes} - 64'h1;
  assign span     = {12'h0, req_addr[1:0]} + {1'b0, req_bytes} + 14'h3;
  // hint only on reads where completing all bytes is harmless; a
  // flush or empty request keeps its zero enables, since a hint
  // would imply every byte and so read the target
  assign hint_ok  = processing_hint_flag && (req_kind == REQ_MEM_RD)
                    && !req_nonprefetch
                    && !req_flush && (req_bytes != 13'h0);

  // lengths count partial end words; a count beyond the length
  // field wraps, so callers keep each request within its range
  always_comb begin
    // default: a run from the start byte to the end byte
    len_d   = span[11:2];
    first_d = BE_ALL << req_addr[1:0];
    final_d = BE_ALL >> (2'h3 - end_addr[1:0]);
    if (req_flush || req_bytes == 13'h0) begin
      // zero-length: one dword, nothing enabled, keep caller's address
      len_d   = LEN_ONE;
      first_d = BE_NONE;
      final_d = BE_NONE;
    end else if (len_d == LEN_ONE) begin
      first_d = first_d & final_d;
      final_d = BE_NONE;
    end
    if (hint_ok) begin
      first_d = steering_tag_field[3:0];
      final_d = steering_tag_field[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checking: one path for formed requests, one for raw headers
  logic [3:0] chk_first;
  logic [3:0] chk_final;
  logic [9:0] chk_len;
  logic       chk_mem;
  logic       chk_aligned;
  logic       chk_hint;
  logic       first_contig;
  logic       final_contig;
  logic       bad;

  // raw headers give no address, so they count as unaligned
  always_comb begin
    if (raw_valid) begin
      chk_first   = raw_byte7[FIRST_LSB +: BE_W];
      chk_final   = raw_byte7[FINAL_LSB +: BE_W];
      chk_len     = raw_len;
      chk_mem     = raw_mem;
      chk_aligned = 1'b0;
      chk_hint    = 1'b0;
    end else begin
      chk_first   = first_d;
      chk_final   = final_d;
      chk_len     = len_d;
      chk_mem     = (req_kind == REQ_MEM_RD) || (req_kind == REQ_MEM_WR);
      chk_aligned = (req_addr[2] == 1'b0);
      chk_hint    = hint_ok;
    end
  end

  be_contig u_first (
    .be          (chk_first),
    .toward_high (1'b1),
    .ok          (first_contig)
  );

  be_contig u_final (
    .be          (chk_final),
    .toward_high (1'b0),
    .ok          (final_contig)
  );

  // each check stands alone; hint headers carry tags, not enables
  logic multi_dw;
  logic sparse_ok;
  logic viol_final_one;
  logic viol_first_empty;
  logic viol_final_empty;
  logic viol_contig;

  // a one-dword request never uses the final field
  assign multi_dw         = (chk_len != LEN_ONE);
  // aligned two-dword memory requests may be sparse in both fields
  assign sparse_ok        = chk_mem && (chk_len == LEN_TWO) && chk_aligned;
  assign viol_final_one   = !multi_dw && (chk_final != BE_NONE);
  assign viol_first_empty = multi_dw && (chk_first == BE_NONE);
  assign viol_final_empty = multi_dw && (chk_final == BE_NONE);
  // other multi-dword requests (not aligned two-dword memory): runs must touch the interior
  assign viol_contig      = multi_dw && !sparse_ok
                            && !(first_contig && final_contig);

  always_comb begin
    bad = 1'b0;
    if (!chk_hint) begin
      bad = viol_final_one || viol_first_empty || viol_final_empty
            || viol_contig;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // header output register
  logic take;
  // a raw header wins over a formed request in the same cycle
  assign take = req_valid || raw_valid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_valid   <= 1'b0;
      hdr_byte7   <= HDR_RESET;
      hdr_len     <= 10'h0;
      hdr_dw_addr <= 62'h0;
      hdr_class   <= 3'h0;
      hdr_hint    <= 1'b0;
    end else if (clk_en) begin
      hdr_valid <= take;
      if (take) begin
        hdr_byte7   <= {chk_final, chk_first};
        hdr_len     <= chk_len;
        hdr_dw_addr <= req_addr[63:2];
        hdr_class   <= service_class_field;
        hdr_hint    <= chk_hint;
      end
    end
  end

  // malformed pulse and discard mark, only when checking is on
  // the pulse stands one cycle; the discard mark stays with the header
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      malformed_err <= 1'b0;
      hdr_discard   <= 1'b0;
    end else if (clk_en) begin
      malformed_err <= take && check_enable && bad;
      if (take) begin
        hdr_discard <= check_enable && bad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // enables a completer must honour, implied for hint reads
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      impl_first_be <= BE_NONE;
      impl_final_be <= BE_NONE;
    end else if (clk_en && take) begin
      if (chk_hint) begin
        impl_first_be <= BE_ALL;
        impl_final_be <= (chk_len == LEN_ONE) ? BE_NONE : BE_ALL;
      end else begin
        // plain requests pass their own enables straight through
        impl_first_be <= chk_first;
        impl_final_be <= chk_final;
      end
    end
  end
endmodule // be_former

//--- core/be_pkg.sv
// Purpose: shared constants for the request byte-enable former
// Assumes: dword lengths in units of 4 bytes, length field 10 bits
// Notes:   header byte 7 carries both enable fields
package be_pkg;
  localparam int          LEN_W          = 10;
  localparam int          ADDR_W         = 64;
  localparam int          BE_W           = 4;
  localparam int          HDR_BYTE_BE    = 7;   // header byte with enables
  localparam int          FIRST_LSB      = 0;   // first field bit position
  localparam int          FINAL_LSB      = 4;   // final field bit position
  localparam logic [3:0]  BE_NONE        = 4'h0;
  localparam logic [3:0]  BE_ALL         = 4'hf;
  localparam logic [9:0]  LEN_ONE        = 10'h001;
  localparam logic [9:0]  LEN_TWO        = 10'h002;
  localparam logic [7:0]  HDR_RESET      = 8'h00;
  typedef enum logic [1:0] {
    REQ_MEM_RD,
    REQ_MEM_WR,
    REQ_IO,
    REQ_CFG
  } req_kind_t;
endpackage

//--- core/be_contig.sv
// Purpose: contiguity test of one 4-bit enable field
// Assumes: purely combinational
// Notes:   toward_high: the set bits must reach bit 3 (first dword);
//          otherwise they must reach bit 0 (final dword)
`timescale 1ns/100ps
module be_contig (
  input  wire logic [3:0] be,
  input  wire logic       toward_high,
  output logic            ok
);
  import be_pkg::*;

  // legal patterns are a solid run touching the interior edge
  always_comb begin
    if (toward_high) begin
      ok = (be == 4'h8) || (be == 4'hc) || (be == 4'he) || (be == 4'hf);
    end else begin
      ok = (be == 4'h1) || (be == 4'h3) || (be == 4'h7) || (be == 4'hf);
    end
  end
endmodule // be_contig

//--- verif/be_former_sva.sv
// Purpose: port assertions for the byte-enable former
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every be_former below
`timescale 1ns/100ps
module be_former_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       check_enable,
  input wire logic       req_valid,
  input wire logic       req_flush,
  input wire logic       raw_valid,
  input wire logic [2:0] service_class_field,
  input wire logic       hdr_valid,
  input wire logic [7:0] hdr_byte7,
  input wire logic [9:0] hdr_len,
  input wire logic [2:0] hdr_class,
  input wire logic       hdr_hint,
  input wire logic       hdr_discard,
  input wire logic       malformed_err,
  input wire logic [3:0] impl_first_be,
  input wire logic [3:0] impl_final_be
);
  //////////////////////////////
  // a header is taken on this edge
  wire take = clk_en && (req_valid || raw_valid);
  wire fmt = hdr_valid && !hdr_hint && !hdr_discard;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a formed request, no raw header competing
  sequence req_s;
    clk_en && req_valid && !raw_valid;
  endsequence
  // a take bound by the enable rules: formed, or raw with checks on;
  // a raw header taken with checks off carries no promise
  sequence sure_take_s;
    take && (check_enable || !raw_valid);
  endsequence
  // the plain header that such a take yields one cycle later
  sequence sure_hdr_s;
    sure_take_s ##1 (hdr_valid && !hdr_hint && !hdr_discard);
  endsequence

  answer_next_a: assert property (
    take |=> hdr_valid)
    else $error("no header one cycle after take");
  err_discard_a: assert property (
    malformed_err |-> hdr_valid && hdr_discard)
    else $error("error without discarded header");
  single_final_a: assert property (
    sure_hdr_s ##0 (hdr_len == 10'h001) |-> hdr_byte7[7:4] == 4'h0)
    else $error("final enables set on one dword");
  multi_nonzero_a: assert property (
    sure_hdr_s ##0 (hdr_len > 10'h001) |-> hdr_byte7[3:0] != 4'h0
    && hdr_byte7[7:4] != 4'h0)
    else $error("empty enable field on long request");
  hint_implied_a: assert property (
    hdr_valid && hdr_hint |-> impl_first_be == 4'hf
    && impl_final_be == (hdr_len == 10'h001 ? 4'h0 : 4'hf))
    else $error("wrong implied enables on hint read");
  enables_kept_a: assert property (
    fmt |-> {impl_final_be, impl_first_be} == hdr_byte7)
    else $error("completer enables differ from header");
  quiet_off_a: assert property (
    take && !check_enable |=> !malformed_err)
    else $error("error raised with checks off");
  flush_zero_a: assert property (
    req_s ##0 req_flush |=> hdr_len == 10'h001 && hdr_byte7 == 8'h00)
    else $error("flush not a zero-length read");
  class_copy_a: assert property (
    req_s |=> hdr_class == $past(service_class_field))
    else $error("service class not carried");
endmodule // be_former_chk
bind be_former be_former_chk be_former_chk_i (.*);

//--- verif/be_completer.sv
// Purpose: completer model fed by formed headers
// Assumes: one dword target word, header kind not seen
// Notes:   enabled bytes are toggled, others left alone
`timescale 1ns/100ps
module be_completer (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        hdr_valid,
  input wire logic        hdr_discard,
  input wire logic [9:0]  hdr_len,
  input wire logic [3:0]  impl_first_be,
  output logic     [31:0] word_q,
  output logic     [9:0]  cpl_len_q
);
  //////////////////////////////
  // touch only enabled bytes; no enables, no side effect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) word_q <= '0;
    else if (hdr_valid && !hdr_discard) begin
      for (int b = 0; b < 4; b++) begin
        if (impl_first_be[b]) word_q[8*b +: 8] <= ~word_q[8*b +: 8];
      end
    end
  end
  // completion length follows request, one dword when empty
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cpl_len_q <= '0;
    else if (hdr_valid) cpl_len_q <= hdr_len;
  end
endmodule // be_completer

//--- verif/tb_be_former.sv
// Purpose: directed bench for the byte-enable former
// Assumes: answer exactly one cycle after take
// Notes:   raw headers come back unchanged in byte 7
`timescale 1ns/100ps
module tb_be_former;
  import be_pkg::*;
  logic ref_clk, rst_n, clk_en, check_enable, req_valid, req_flush;
  logic req_nonprefetch, processing_hint_flag, raw_valid, raw_mem;
  logic hdr_valid, hdr_hint, hdr_discard, malformed_err;
  req_kind_t   req_kind;
  logic [63:0] req_addr;
  logic [12:0] req_bytes;
  logic [7:0]  steering_tag_field, raw_byte7, hdr_byte7;
  logic [2:0]  service_class_field, hdr_class;
  logic [9:0]  raw_len, hdr_len, cpl_len_q;
  logic [61:0] hdr_dw_addr;
  logic [3:0]  impl_first_be, impl_final_be;
  logic [31:0] word_q, keep;
  int          errors, checked;
  be_former be_former_i (.*);
  be_completer be_completer_i (.*);
  //////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // take edge, then look at the answer just after it
  task automatic go(input logic [7:0] e7, input logic [9:0] el,
                    input logic ee);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    raw_valid <= 1'b0;
    #1;
    chk("valid", hdr_valid, 1'b1);
    chk("byte7", hdr_byte7, e7);
    chk("len", hdr_len, el);
    chk("err", malformed_err, ee);
    chk("discard", hdr_discard, ee);
    @(posedge ref_clk);
  endtask
  task automatic rq(input req_kind_t k, input logic [15:0] a,
                    input logic [12:0] n, input logic [7:0] e7,
                    input logic [9:0] el);
    req_kind <= k;
    req_addr <= {48'h0, a};
    req_bytes <= n;
    req_valid <= 1'b1;
    go(e7, el, 1'b0);
  endtask
  task automatic rw(input logic [7:0] b, input logic [9:0] l,
                    input logic ee);
    raw_byte7 <= b;
    raw_len <= l;
    raw_valid <= 1'b1;
    go(b, l, ee);
  endtask
  // main sequence
  initial begin
    {clk_en, check_enable, req_valid, req_flush, raw_valid} = '0;
    {req_nonprefetch, processing_hint_flag, raw_mem, rst_n} = 4'h2;
    req_kind = REQ_MEM_RD;
    {req_addr, req_bytes, steering_tag_field} = '0;
    {raw_byte7, raw_len} = '0;
    service_class_field = 3'h5;
    repeat (10) @(posedge ref_clk);
    {rst_n, clk_en, check_enable} <= 3'h7;
    @(posedge ref_clk);
    rq(REQ_MEM_RD, 16'h1001, 13'h006, 8'h7e, 10'h002);
    rq(REQ_MEM_WR, 16'h2002, 13'h001, 8'h04, 10'h001);
    rq(REQ_MEM_WR, 16'h3000, 13'h004, 8'h0f, 10'h001);
    rq(REQ_MEM_RD, 16'h4003, 13'h00a, 8'h18, 10'h004);
    rq(REQ_IO, 16'h6001, 13'h002, 8'h06, 10'h001);
    rq(REQ_CFG, 16'h7004, 13'h004, 8'h0f, 10'h001);
    #1 keep = word_q;
    chk("word", word_q, 32'h00ff0000);
    @(posedge ref_clk);
    rq(REQ_MEM_WR, 16'h7004, 13'h000, 8'h00, 10'h001);
    req_flush <= 1'b1;
    rq(REQ_MEM_RD, 16'h7004, 13'h008, 8'h00, 10'h001);
    #1 chk("word", word_q, keep);
    chk("cpl_len", cpl_len_q, 10'h001);
    chk("class", hdr_class, 3'h5);
    chk("dw_addr", hdr_dw_addr[31:0], 32'h00001c01);
    $display("forming test done");
    @(posedge ref_clk);
    {req_flush, processing_hint_flag} <= 2'h1;
    steering_tag_field <= 8'h5a;
    rq(REQ_MEM_RD, 16'h8000, 13'h008, 8'h5a, 10'h002);
    chk("impl", {impl_final_be, impl_first_be}, 8'hff);
    chk("hint", hdr_hint, 1'b1);
    req_nonprefetch <= 1'b1;
    rq(REQ_MEM_RD, 16'h8000, 13'h008, 8'hff, 10'h002);
    chk("hint", hdr_hint, 1'b0);
    rw(8'h00, 10'h002, 1'b1);
    rw(8'h10, 10'h001, 1'b1);
    rw(8'h05, 10'h001, 1'b0);
    rw(8'h35, 10'h003, 1'b1);
    rw(8'h0f, 10'h002, 1'b1);
    check_enable <= 1'b0;
    rw(8'h00, 10'h002, 1'b0);
    // enable low: a pending raw header must wait for the clock enable
    clk_en <= 1'b0;
    raw_valid <= 1'b1;
    @(posedge ref_clk);
    #1 chk("frozen", hdr_valid, 1'b0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    go(8'h00, 10'h002, 1'b0);
    $display("checking test done");
    finish_test;
  end
endmodule // tb_be_former
